// [wwdog_core.sv]
// wwdog_core: windowed watchdog counter, feed checker and fault outputs
// assumes: tick clocks arrive asynchronously and are synchronised here;
// control bits come as plain ports from the system register file
`timescale 1ns/10ps
`default_nettype none
module wwdog_core (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   // tick sources
   input  wire logic        internal_rc_oscillator_i,
   input  wire logic        dedicated_slow_oscillator_i,
   // control
   input  wire logic        enable_set_i,
   input  wire logic        reset_enable_i,
   input  wire logic        window_enable_i,
   input  wire logic        clock_select_i,
   input  wire logic [23:0] reload_value_i,
   input  wire logic [23:0] window_value_i,
   input  wire logic [9:0]  warning_value_i,
   // feed and register accesses
   input  wire logic        feed_write_i,
   input  wire logic [7:0]  feed_data_i,
   input  wire logic        other_access_i,
   // flag handling
   input  wire logic        timeout_flag_clear_i,
   input  wire logic        warning_flag_clear_i,
   input  wire logic        reset_cause_clear_i,
   input  wire logic        power_on_i,
   // status and events
   output logic [23:0]      count_o,
   output logic             enabled_o,
   output logic             timeout_flag_o,
   output logic             warning_flag_o,
   output logic             reset_cause_o,
   output logic             interrupt_o,
   output logic             chip_reset_o
);
   // tick source synchronisers
   logic [2:0] sync_rc, sync_slow;
   logic tick_level, tick_prev, next_tick_prev;
   logic tick_rise;
   logic [1:0] prescale, next_prescale;
   logic [23:0] count, next_count;
   logic enabled, next_enabled;
   logic timeout_flag, next_timeout_flag;
   logic warning_flag, next_warning_flag;
   logic reset_cause, next_reset_cause;
   logic chip_reset, next_chip_reset;
   logic [23:0] reload_q, next_reload_q;
   wwdog_pkg::wwdog_feed_e feed_st, next_feed_st;
   logic feed_ok, feed_bad, feed_early, timeout_hit, fault, dec;

   // three-stage synchroniser, change counted when stages two and three agree
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         sync_rc   <= 3'h0;
         sync_slow <= 3'h0;
      end else begin
         sync_rc   <= {sync_rc[1:0], internal_rc_oscillator_i};
         sync_slow <= {sync_slow[1:0], dedicated_slow_oscillator_i};
      end
   end

   // tick select; the filtered level only moves when stages two and three agree
   always_comb begin
      if (clock_select_i == wwdog_pkg::SRC_SLOW_OSC)
         tick_level = (sync_slow[2] == sync_slow[1]) ? sync_slow[1] : tick_prev;
      else
         tick_level = (sync_rc[2] == sync_rc[1]) ? sync_rc[1] : tick_prev;
      tick_rise = tick_level & ~tick_prev;
   end

   // feed checker and fault decode
   always_comb begin
      next_feed_st = feed_st;
      feed_ok      = 1'b0;
      feed_bad     = 1'b0;
      case (feed_st)
         wwdog_pkg::WWDOG_IDLE: begin
            if (feed_write_i) begin
               if (feed_data_i == wwdog_pkg::FEED_FIRST)
                  next_feed_st = wwdog_pkg::WWDOG_HALF;
               else
                  feed_bad = enabled;
            end
         end
         wwdog_pkg::WWDOG_HALF: begin
            if (feed_write_i) begin
               if (feed_data_i == wwdog_pkg::FEED_SECOND)
                  feed_ok = 1'b1;
               else
                  feed_bad = enabled;
               next_feed_st = wwdog_pkg::WWDOG_IDLE;
            end else if (other_access_i) begin
               feed_bad     = enabled;
               next_feed_st = wwdog_pkg::WWDOG_IDLE;
            end
         end
         default: next_feed_st = wwdog_pkg::WWDOG_IDLE;
      endcase
      feed_early  = feed_ok & enabled & window_enable_i & (count > window_value_i);
      timeout_hit = enabled & dec & (count == 24'h000000);
      fault       = timeout_hit | feed_bad | feed_early;
   end

   // counter, prescaler and enable
   always_comb begin
      next_tick_prev = tick_level;
      next_prescale  = prescale;
      next_count     = count;
      next_enabled   = enabled;
      next_reload_q  = reload_q;
      dec            = 1'b0;
      if (reload_value_i < wwdog_pkg::CNT_MIN)
         next_reload_q = wwdog_pkg::CNT_MIN;
      else
         next_reload_q = reload_value_i;
      if (enabled && tick_rise) begin
         next_prescale = prescale + 2'h1;
         dec           = (prescale == wwdog_pkg::PRESCALE_MAX);
      end
      if (dec && count != 24'h000000)
         next_count = count - 24'h000001;
      if ((feed_ok && !feed_early) || (enable_set_i && !enabled)) begin
         next_count    = reload_q;
         next_prescale = 2'h0;
      end
      // set only, cleared by a watchdog event when reset generation is off
      if (enable_set_i)
         next_enabled = 1'b1;
      if (fault && !reset_enable_i)
         next_enabled = 1'b0;
   end

   // flags; set wins over clear
   always_comb begin
      next_timeout_flag = timeout_flag;
      next_warning_flag = warning_flag;
      next_reset_cause  = reset_cause;
      next_chip_reset   = 1'b0;
      if (timeout_flag_clear_i)
         next_timeout_flag = 1'b0;
      if (fault)
         next_timeout_flag = 1'b1;
      if (warning_flag_clear_i)
         next_warning_flag = 1'b0;
      if (enabled && dec && count == {14'h0000, warning_value_i})
         next_warning_flag = 1'b1;
      if (reset_cause_clear_i || power_on_i)
         next_reset_cause = 1'b0;
      if (fault && reset_enable_i) begin
         next_chip_reset  = 1'b1;
         next_reset_cause = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         tick_prev    <= 1'b0;
         prescale     <= 2'h0;
         count        <= wwdog_pkg::CNT_RESET;
         enabled      <= 1'b0;
         timeout_flag <= 1'b0;
         warning_flag <= 1'b0;
         chip_reset   <= 1'b0;
         reload_q     <= wwdog_pkg::CNT_RESET;
         feed_st      <= wwdog_pkg::WWDOG_IDLE;
      end else begin
         tick_prev    <= next_tick_prev;
         prescale     <= next_prescale;
         count        <= next_count;
         enabled      <= next_enabled;
         timeout_flag <= next_timeout_flag;
         warning_flag <= next_warning_flag;
         chip_reset   <= next_chip_reset;
         reload_q     <= next_reload_q;
         feed_st      <= next_feed_st;
      end
   end

   // cause flag survives the reset it caused
   always_ff @(posedge mclk_i) begin
      reset_cause <= next_reset_cause;
   end

   // outputs
   assign count_o        = count;
   assign enabled_o      = enabled;
   assign timeout_flag_o = timeout_flag;
   assign warning_flag_o = warning_flag;
   assign reset_cause_o  = reset_cause;
   assign interrupt_o    = (timeout_flag & ~reset_enable_i) | warning_flag;
   assign chip_reset_o   = chip_reset;

   // assertions
   a_enable_sticky: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      enabled && !fault |=> enabled) else $error("enable dropped without event");
   a_timeout_reset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      timeout_hit && reset_enable_i |=> chip_reset_o && reset_cause_o) else $error("timeout gave no reset");
   a_window_fault: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      feed_ok && enabled && window_enable_i && count > window_value_i |=> timeout_flag_o)
      else $error("early feed not flagged");
   a_bad_feed: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      feed_bad && !reset_enable_i |=> timeout_flag_o && !chip_reset_o) else $error("bad feed wrong response");
   a_count_width: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      dec && count != 24'h000000 && !feed_ok |=> count_o == $past(count) - 24'h000001)
      else $error("counter step wrong");
   a_prescale_four: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      enabled && tick_rise && prescale != wwdog_pkg::PRESCALE_MAX && !feed_ok |=> count_o == $past(count))
      else $error("count moved before fourth tick");
   a_reload_floor: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      reload_q >= wwdog_pkg::CNT_MIN) else $error("reload below floor");
   a_warn_point: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      enabled && dec && count == {14'h0000, warning_value_i} |=> warning_flag_o)
      else $error("warning missed");
   a_feed_pair: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      feed_st == wwdog_pkg::WWDOG_HALF && other_access_i && !feed_write_i && enabled |=> timeout_flag_o)
      else $error("split feed not flagged");
endmodule
`default_nettype wire

// [wwdog_pkg.sv]
// wwdog_pkg: constants for the windowed watchdog
// assumes: single clock mclk_i at 40 MHz, no register bus
package wwdog_pkg;
   localparam int unsigned CNT_W        = 24;
   localparam logic [23:0] CNT_MIN      = 24'h0000ff;  // reload values below this are raised to it
   localparam logic [23:0] CNT_RESET    = 24'h0000ff;
   localparam logic [23:0] WINDOW_RESET = 24'hffffff;
   localparam logic [9:0]  WARN_RESET   = 10'h000;
   localparam logic [1:0]  PRESCALE_MAX = 2'h3;        // divide by four
   localparam logic [7:0]  FEED_FIRST   = 8'haa;
   localparam logic [7:0]  FEED_SECOND  = 8'h55;
   localparam logic        SRC_INT_RC   = 1'b0;
   localparam logic        SRC_SLOW_OSC = 1'b1;

   typedef enum logic [2:0] {
      WWDOG_IDLE = 3'b001,
      WWDOG_HALF = 3'b010,
      WWDOG_DONE = 3'b100
   } wwdog_feed_e;
endpackage

// [wwdog_core_test.sv]
// wwdog_core_test: self-checking bench for the windowed watchdog core
// assumes: wwdog_pkg and wwdog_core compiled first; design assertions run inline
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
$display("Error %s expected %h seen %h", nm, exp, got); end end
module wwdog_core_test;
   logic        mclk_i, resetn_i, rc, slow, en_set, rst_en, win_en, csel;
   logic        fwr, oacc, tclr, wclr, rclr, pwr;
   logic [23:0] reload, window, count;
   logic [9:0]  warn;
   logic [7:0]  fdata;
   logic        enabled, tflag, wflag, rcause, irq, crst;
   int          miscompares, n_compared, n_rst, cyc, k;

   wwdog_core i_wwdog_core (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .internal_rc_oscillator_i(rc),
      .dedicated_slow_oscillator_i(slow), .enable_set_i(en_set), .reset_enable_i(rst_en),
      .window_enable_i(win_en), .clock_select_i(csel), .reload_value_i(reload),
      .window_value_i(window), .warning_value_i(warn), .feed_write_i(fwr), .feed_data_i(fdata),
      .other_access_i(oacc), .timeout_flag_clear_i(tclr), .warning_flag_clear_i(wclr),
      .reset_cause_clear_i(rclr), .power_on_i(pwr), .count_o(count), .enabled_o(enabled),
      .timeout_flag_o(tflag), .warning_flag_o(wflag), .reset_cause_o(rcause),
      .interrupt_o(irq), .chip_reset_o(crst));

   // clock at 25 ns
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   // counts chip reset cycles away from the launching edge and cuts a hang short
   always @(negedge mclk_i) begin
      cyc++;
      if (crst === 1'b1) n_rst++;
      if (cyc == 40000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // synchronous reset held three cycles
   task automatic do_reset();
      @(negedge mclk_i) resetn_i = 1'b0;
      repeat (3) @(negedge mclk_i);
      resetn_i = 1'b1;
      pwr      = 1'b0;
      @(negedge mclk_i);
   endtask

   // one-cycle pulse on a control input
   task automatic pulse(ref logic s);
      @(negedge mclk_i) s = 1'b1;
      @(negedge mclk_i) s = 1'b0;
      @(negedge mclk_i);
   endtask

   // n tick periods on one source, each 17 clocks long
   task automatic tick(input logic src, input int n);
      repeat (n) begin
         @(negedge mclk_i) if (src) slow = 1'b1; else rc = 1'b1;
         repeat (8) @(negedge mclk_i);
         rc   = 1'b0;
         slow = 1'b0;
         repeat (8) @(negedge mclk_i);
      end
   endtask

   // two feed writes; mid = 1 puts another access between them
   task automatic feed(input logic [7:0] a, input logic [7:0] b, input logic mid);
      @(negedge mclk_i) fwr = 1'b1;
      fdata = a;
      if (mid) begin
         @(negedge mclk_i) fwr = 1'b0;
         oacc = 1'b1;
         @(negedge mclk_i) oacc = 1'b0;
         fwr = 1'b1;
      end else @(negedge mclk_i);
      fdata = b;
      @(negedge mclk_i) fwr = 1'b0;
      repeat (2) @(negedge mclk_i);
   endtask

   initial begin
      {rc, slow, en_set, rst_en, win_en, csel, fwr, oacc, tclr, wclr, rclr} = '0;
      {pwr, resetn_i} = 2'b10;
      reload = 24'h000010;
      window = 24'hffffff;
      warn   = 10'h000;
      fdata  = 8'h00;
      do_reset();
      `CHK("count", 24'h0000ff, count)
      `CHK("enabled", 1'b0, enabled)
      `CHK("cause", 1'b0, rcause)
      {csel, rst_en} = 2'b11;
      pulse(en_set);
      `CHK("enabled", 1'b1, enabled)
      `CHK("count", 24'h0000ff, count)
      tick(1'b0, 4);
      `CHK("count", 24'h0000ff, count)
      tick(1'b1, 7);
      `CHK("count", 24'h0000fe, count)
      tick(1'b1, 1);
      `CHK("count", 24'h0000fd, count)
      reload = 24'h000200;
      feed(wwdog_pkg::FEED_FIRST, wwdog_pkg::FEED_SECOND, 1'b0);
      `CHK("count", 24'h000200, count)
      `CHK("enabled", 1'b1, enabled)
      reload = 24'h000010;
      // wrong data, then another access between the two writes
      for (k = 0; k < 2; k++) begin
         do_reset();
         pulse(en_set);
         n_rst = 0;
         feed(wwdog_pkg::FEED_FIRST, (k == 0) ? 8'h12 : wwdog_pkg::FEED_SECOND, k[0]);
         // a split pair also refuses the late second write, so it holds reset one cycle more
         `CHK("pulses", k + 1, n_rst)
         `CHK("cause", 1'b1, rcause)
         `CHK("tflag", 1'b1, tflag)
         do_reset();
         `CHK("cause", 1'b1, rcause)
         `CHK("enabled", 1'b0, enabled)
         pulse(rclr);
         `CHK("cause", 1'b0, rcause)
      end
      // window: feed in range accepted, early feed interrupts
      {win_en, rst_en} = 2'b10;
      window = 24'h0000fe;
      pulse(en_set);
      tick(1'b1, 4);
      reload = 24'h000200;
      feed(wwdog_pkg::FEED_FIRST, wwdog_pkg::FEED_SECOND, 1'b0);
      `CHK("count", 24'h000200, count)
      `CHK("tflag", 1'b0, tflag)
      n_rst = 0;
      feed(wwdog_pkg::FEED_FIRST, wwdog_pkg::FEED_SECOND, 1'b0);
      `CHK("irq", 1'b1, irq)
      `CHK("pulses", 0, n_rst)
      `CHK("enabled", 1'b0, enabled)
      pulse(tclr);
      `CHK("irq", 1'b0, irq)
      // wrong data with reset generation off gives an interrupt only
      pulse(en_set);
      n_rst = 0;
      feed(wwdog_pkg::FEED_FIRST, 8'h12, 1'b0);
      `CHK("irq", 1'b1, irq)
      `CHK("tflag", 1'b1, tflag)
      `CHK("pulses", 0, n_rst)
      pulse(tclr);
      // warning interrupt ahead of time-out
      {win_en, rst_en, csel} = 3'b010;
      reload = 24'h000010;
      warn   = 10'h0fe;
      do_reset();
      pulse(en_set);
      tick(1'b0, 4);
      `CHK("wflag", 1'b0, wflag)
      tick(1'b0, 4);
      `CHK("wflag", 1'b1, wflag)
      `CHK("count", 24'h0000fd, count)
      `CHK("irq", 1'b1, irq)
      pulse(wclr);
      `CHK("wflag", 1'b0, wflag)
      // full time-out from the minimum reload
      csel = 1'b1;
      do_reset();
      pulse(en_set);
      n_rst = 0;
      tick(1'b1, 1023);
      `CHK("pulses", 0, n_rst)
      tick(1'b1, 1);
      `CHK("pulses", 1, n_rst)
      `CHK("cause", 1'b1, rcause)
      tally_and_finish();
   end
endmodule
`default_nettype wire
